/* File: rtl/mmc_top.sv */
// Management-side control and status logic of a pluggable transceiver module.
// Assumes a two-wire serial engine outside that runs on the serial clock and
// reports finished writes and status reads as strobes on that clock's falling edge.
//
// What this block does
// - Fully functional within 2000 ms after reset.
// - Reset only on low beyond 2 us.
// - Serial bus answers within 2000 ms.
// - Clear data-not-ready, assert interrupt within 2000 ms.
// - Data-not-ready clearing raises the interrupt.
// - Low-power pin enters low power within 100us.
// - Interrupt goes low within 200 ms.
// - Reading flags clears them, releasing interrupt.
// - Loss-of-signal flag and interrupt within 100ms.
// - Any condition sets flag, interrupt within 200ms.
// - Setting mask inhibits interrupt within 100ms.
// - Clearing mask resumes interrupt within 100ms.
// - Select asserted: answer bus within 100us.
// - Select released: stop answering within 100us.
// - Power-down bit enters low power within 100ms.
// - Power-down cleared: full operation within 300ms.
// - Write delays count from falling serial clock.
`include "mmc_cfg.svh"
`timescale 1ns/1ns

module mmc_top #(
  parameter int NFLAG       = `MMC_NFLAG,
  parameter int INIT_CYCLES = `MMC_T_INIT_MS * (`MMC_NS_PER_MS / `MMC_CLK_PERIOD_NS),
  parameter int RST_MIN_CYC = (`MMC_T_RST_MIN_NS + `MMC_CLK_PERIOD_NS - 1) / `MMC_CLK_PERIOD_NS
)
(
  input  wire logic             CORE_CLK,
  input  wire logic             RST,
  input  wire logic             SCL_CLK,
  input  wire logic             MODULE_RESET_IN_N,
  input  wire logic             BUS_SELECT_IN_N,
  input  wire logic             LOW_POWER_IN,
  input  wire logic [NFLAG-1:0] COND_IN,
  input  wire logic             LINK_WR_STB,
  input  wire logic [NFLAG-1:0] LINK_WR_MASK,
  input  wire logic             LINK_WR_PDOWN,
  input  wire logic             LINK_RD_STB,
  input  wire logic [NFLAG-1:0] LINK_RD_VAL,
  output logic                  IRQ_OUT_N,
  output logic                  PRESENT_OUT_N,
  output logic                  BUS_ENABLE,
  output logic                  LOW_POWER_OUT,
  output logic                  DATA_NOT_READY,
  output logic                  INIT_EVENT,
  output logic [NFLAG-1:0]      FLAGS,
  output logic [NFLAG-1:0]      MASK_Q,
  output logic                  PDOWN_Q
);

  localparam int ICW = $clog2(INIT_CYCLES + 1);
  localparam int RCW = $clog2(RST_MIN_CYC + 1);
  localparam logic [ICW-1:0] INIT_LAST = ICW'(INIT_CYCLES - 1);
  localparam logic [RCW-1:0] RST_LAST  = RCW'(RST_MIN_CYC);

  // ---- Serial clock domain, falling edge ----
  logic             lrst1_ff;
  logic             lrst2_ff;
  logic             wr_tog_ff;
  logic             rd_tog_ff;
  logic [NFLAG-1:0] mask_l_ff;
  logic             pdn_l_ff;
  logic [NFLAG-1:0] rdv_l_ff;

  // The core reset is foreign to the serial clock, so it is synchronised there.
  // The serial clock must run a few edges during reset for this to take effect.
  always_ff @(negedge SCL_CLK)
  begin
    lrst1_ff <= RST;
    lrst2_ff <= lrst1_ff;
  end

  // Writes are captured on the falling serial edge that ends the transaction.
  // falling edge timing
  always_ff @(negedge SCL_CLK)
  begin
    if (lrst2_ff)
    begin
      wr_tog_ff <= 1'b0;
      mask_l_ff <= '0;
      pdn_l_ff  <= 1'b0;
    end
    else if (LINK_WR_STB)
    begin
      wr_tog_ff <= ~wr_tog_ff;
      mask_l_ff <= LINK_WR_MASK;
      pdn_l_ff  <= LINK_WR_PDOWN;
    end
  end

  // Status reads hold the value the host saw, so only those bits are cleared.
  always_ff @(negedge SCL_CLK)
  begin
    if (lrst2_ff)
    begin
      rd_tog_ff <= 1'b0;
      rdv_l_ff  <= '0;
    end
    else if (LINK_RD_STB)
    begin
      rd_tog_ff <= ~rd_tog_ff;
      rdv_l_ff  <= LINK_RD_VAL;
    end
  end

  // ---- Core clock domain ----
  logic             rpin1_ff;
  logic             rpin2_ff;
  logic             sel1_ff;
  logic             sel2_ff;
  logic             lp1_ff;
  logic             lp2_ff;
  logic [NFLAG-1:0] cond1_ff;
  logic [NFLAG-1:0] cond2_ff;
  logic [NFLAG-1:0] cond3_ff;
  logic             wt1_ff;
  logic             wt2_ff;
  logic             wt3_ff;
  logic             rt1_ff;
  logic             rt2_ff;
  logic             rt3_ff;
  logic             wr_evt;
  logic             rd_evt;

  // Every pin passes two flops before use. These stages carry no reset, as
  // the pins are levels that settle again within two cycles of any reset.
  always_ff @(posedge CORE_CLK)
  begin
    rpin1_ff <= MODULE_RESET_IN_N;
    rpin2_ff <= rpin1_ff;
    sel1_ff  <= BUS_SELECT_IN_N;
    sel2_ff  <= sel1_ff;
    lp1_ff   <= LOW_POWER_IN;
    lp2_ff   <= lp1_ff;
    cond1_ff <= COND_IN;
    cond2_ff <= cond1_ff;
  end

  // Toggle synchronisers and the third stage for edge detection, which reads
  // only the second stage. The toggle chains clear with the core reset, so an
  // unknown or stale toggle cannot pose as a write or read just after release.
  // The serial side clears its toggles during reset too, so both agree on zero.
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cond3_ff <= '0;
      wt1_ff   <= 1'b0;
      wt2_ff   <= 1'b0;
      wt3_ff   <= 1'b0;
      rt1_ff   <= 1'b0;
      rt2_ff   <= 1'b0;
      rt3_ff   <= 1'b0;
    end
    else
    begin
      cond3_ff <= cond2_ff;
      wt1_ff   <= wr_tog_ff;
      wt2_ff   <= wt1_ff;
      wt3_ff   <= wt2_ff;
      rt1_ff   <= rd_tog_ff;
      rt2_ff   <= rt1_ff;
      rt3_ff   <= rt2_ff;
    end
  end

  assign wr_evt = wt2_ff ^ wt3_ff;
  assign rd_evt = rt2_ff ^ rt3_ff;

  // Reset pin low-time filter; short glitches are ignored.
  logic [RCW-1:0] rlow_cnt_ff;
  logic           mod_rst;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST || rpin2_ff)
      rlow_cnt_ff <= '0;
    else if (rlow_cnt_ff != RST_LAST)
      rlow_cnt_ff <= rlow_cnt_ff + RCW'(1);
  end

  assign mod_rst = !rpin2_ff && (rlow_cnt_ff == RST_LAST);

  // Initialisation sequencer: held while in reset, then a fixed timer.
  mmc_pkg::mmc_state_t state_ff;
  mmc_pkg::mmc_state_t nxt_state;
  logic [ICW-1:0]      init_cnt_ff;
  logic                ready_entry;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      mmc_pkg::MMC_HOLD:
      begin
        if (!mod_rst)
          nxt_state = mmc_pkg::MMC_INIT;
      end
      mmc_pkg::MMC_INIT:
      begin
        if (mod_rst)
          nxt_state = mmc_pkg::MMC_HOLD;
        else if (init_cnt_ff == INIT_LAST)
          nxt_state = mmc_pkg::MMC_READY;
      end
      mmc_pkg::MMC_READY:
      begin
        if (mod_rst)
          nxt_state = mmc_pkg::MMC_HOLD;
      end
      default:
      begin
        nxt_state = mmc_pkg::MMC_HOLD;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      state_ff <= mmc_pkg::MMC_HOLD;
    else
      state_ff <= nxt_state;
  end

  // The timer restarts whenever the sequencer is not counting.
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || state_ff != mmc_pkg::MMC_INIT)
      init_cnt_ff <= '0;
    else
      init_cnt_ff <= init_cnt_ff + ICW'(1);
  end

  assign ready_entry = (state_ff == mmc_pkg::MMC_INIT) && (nxt_state == mmc_pkg::MMC_READY);

  // Data-not-ready stays set until the module is ready.
  // data not ready
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      DATA_NOT_READY <= 1'b1;
    else
      DATA_NOT_READY <= (nxt_state != mmc_pkg::MMC_READY);
  end

  // Readiness event latches like a flag; any status read clears it, set wins.
  // ready raises interrupt
  always_ff @(posedge CORE_CLK)
  begin
    if (RST || mod_rst)
      INIT_EVENT <= 1'b0;
    else if (ready_entry)
      INIT_EVENT <= 1'b1;
    else if (rd_evt)
      INIT_EVENT <= 1'b0;
  end

  // Sticky condition flags, one per bit; a rising condition wins over a read.
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++)
    begin : g_flag
      always_ff @(posedge CORE_CLK)
      begin
        if (RST || mod_rst)
          FLAGS[gi] <= 1'b0;
        else if (cond2_ff[gi] && !cond3_ff[gi])
          FLAGS[gi] <= 1'b1;
        else if (rd_evt && rdv_l_ff[gi])
          FLAGS[gi] <= 1'b0;
      end
    end
  endgenerate

  // Serial-side words are stable while their toggle crosses, so capture is safe.
  // write-triggered updates
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      MASK_Q  <= '0;
      PDOWN_Q <= 1'b0;
    end
    else if (wr_evt)
    begin
      MASK_Q  <= mask_l_ff;
      PDOWN_Q <= pdn_l_ff;
    end
  end

  // Interrupt is low while any unmasked flag or the ready event stands.
  // interrupt assert
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      IRQ_OUT_N <= 1'b1;
    else
      IRQ_OUT_N <= !(INIT_EVENT || (|(FLAGS & ~MASK_Q)));
  end

  // Bus answers only when ready and selected; a few cycles either way.
  // serial ready
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      BUS_ENABLE <= 1'b0;
    else
      BUS_ENABLE <= !sel2_ff && (state_ff == mmc_pkg::MMC_READY);
  end

  // Low power follows the pin or the power-down bit; release is immediate.
  // pin low power
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      LOW_POWER_OUT <= 1'b0;
    else
      LOW_POWER_OUT <= lp2_ff || PDOWN_Q;
  end

  // Presence is tied low through a flop so it is defined from reset onward.
  always_ff @(posedge CORE_CLK)
  begin
    PRESENT_OUT_N <= 1'b0;
  end

endmodule

/* File: rtl/mmc_cfg.svh */
// Timing figures, flag count and flag positions for the module management block.
// Assumes a single core clock whose period is given below in nanoseconds.
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH

// Core clock period in nanoseconds.
`define MMC_CLK_PERIOD_NS      50
// Longest time from power on or reset release to fully functional, in ms.
`define MMC_T_INIT_MS          2000
// Least low time on the module reset pin that counts as a reset, in ns.
`define MMC_T_RST_MIN_NS       2000
// Longest low-power entry time from the low-power pin, in us.
`define MMC_T_LP_PIN_US        100
// Longest interrupt assert and release times, in ms and us.
`define MMC_T_IRQ_ON_MS        200
`define MMC_T_IRQ_OFF_US       500
// Longest select response time, in us.
`define MMC_T_SEL_US           100
// Nanoseconds in one millisecond.
`define MMC_NS_PER_MS          1000000
// Default flag count and field positions.
`define MMC_NFLAG              8
`define MMC_FLAG_LOS           0
`define MMC_FLAG_TXFAULT       1

`endif

/* File: rtl/mmc_pkg.sv */
// Types shared by the module management block.
// Assumes the configuration header is included by the design file.
package mmc_pkg;

  // Initialisation sequence states.
  typedef enum logic [1:0]
  {
    MMC_HOLD,
    MMC_INIT,
    MMC_READY
  } mmc_state_t;

endpackage

/* File: testbench/mmc_monitor.sv */
// Port-timing checker for the management block.
// Sees only the top module ports and is bound to every instance.
`timescale 1ns/1ns
module mmc_monitor #(
  parameter int NFLAG       = 8,
  parameter int INIT_CYCLES = 200,
  parameter int RST_MIN_CYC = 4
)
(
  input wire logic             CORE_CLK,
  input wire logic             RST,
  input wire logic             MODULE_RESET_IN_N,
  input wire logic             BUS_SELECT_IN_N,
  input wire logic             LOW_POWER_IN,
  input wire logic [NFLAG-1:0] COND_IN,
  input wire logic             IRQ_OUT_N,
  input wire logic             BUS_ENABLE,
  input wire logic             LOW_POWER_OUT,
  input wire logic             DATA_NOT_READY,
  input wire logic             INIT_EVENT,
  input wire logic [NFLAG-1:0] FLAGS,
  input wire logic [NFLAG-1:0] MASK_Q,
  input wire logic             PDOWN_Q
);
  int low_ff;
  int wait_ff;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Pin low time and ready wait; a wait past the bound means a stuck sequencer.
  always_ff @(posedge CORE_CLK)
  begin
    low_ff  <= MODULE_RESET_IN_N ? 0 : low_ff + 1;
    wait_ff <= (RST || !DATA_NOT_READY || !MODULE_RESET_IN_N) ? 0 : wait_ff + 1;
  end
  chk_irq_level: assert property (
    IRQ_OUT_N == !($past(INIT_EVENT) || |($past(FLAGS) & ~$past(MASK_Q))))
    else $error("interrupt level wrong");
  chk_ready_irq: assert property (
    $fell(DATA_NOT_READY) |-> INIT_EVENT ##1 !IRQ_OUT_N) else $error("ready without irq");
  chk_init_time: assert property (
    wait_ff <= INIT_CYCLES + 8) else $error("ready too late");
  chk_sel_on: assert property (
    $fell(BUS_SELECT_IN_N) && !DATA_NOT_READY |-> ##[2:6] BUS_ENABLE) else $error("bus late");
  chk_sel_off: assert property (
    $rose(BUS_SELECT_IN_N) |-> ##[2:6] !BUS_ENABLE) else $error("bus stays on");
  chk_bus_ready: assert property (
    DATA_NOT_READY |=> !BUS_ENABLE) else $error("bus on before ready");
  chk_lp_pin: assert property (
    $rose(LOW_POWER_IN) |-> ##[2:6] LOW_POWER_OUT) else $error("low power late");
  chk_pd_low: assert property (
    $rose(PDOWN_Q) |=> LOW_POWER_OUT) else $error("power-down ignored");
  chk_los_flag: assert property (
    $rose(COND_IN[0]) |-> ##[3:7] FLAGS[0]) else $error("loss flag late");
  chk_rst_len: assert property (
    $rose(DATA_NOT_READY) |-> low_ff >= RST_MIN_CYC) else $error("short reset taken");
  cov_ready: cover property ($fell(DATA_NOT_READY));
  cov_flag: cover property ($rose(|FLAGS));
  cov_pdown: cover property ($rose(PDOWN_Q));
endmodule
bind mmc_top mmc_monitor #(.NFLAG(NFLAG), .INIT_CYCLES(INIT_CYCLES), .RST_MIN_CYC(RST_MIN_CYC))
  mmc_monitor_i (.CORE_CLK(CORE_CLK), .RST(RST), .MODULE_RESET_IN_N(MODULE_RESET_IN_N),
  .BUS_SELECT_IN_N(BUS_SELECT_IN_N), .LOW_POWER_IN(LOW_POWER_IN), .COND_IN(COND_IN),
  .IRQ_OUT_N(IRQ_OUT_N), .BUS_ENABLE(BUS_ENABLE), .LOW_POWER_OUT(LOW_POWER_OUT),
  .DATA_NOT_READY(DATA_NOT_READY), .INIT_EVENT(INIT_EVENT), .FLAGS(FLAGS),
  .MASK_Q(MASK_Q), .PDOWN_Q(PDOWN_Q));

/* File: testbench/mmc_host_model.sv */
// Host link model: clocks the serial side only inside frames.
// Assumes the block samples its strobes on falling serial edges.
`timescale 1ns/1ns
module mmc_host_model #(parameter int NFLAG = 8)
(
  output logic             scl,
  output logic             wr_stb,
  output logic [NFLAG-1:0] wr_mask,
  output logic             wr_pd,
  output logic             rd_stb,
  output logic [NFLAG-1:0] rd_val
);
  // Serial clock idles high and no strobe is pending.
  initial
  begin
    {scl, wr_stb, wr_pd, rd_stb} = 4'h8;
    wr_mask = '0;
    rd_val = '0;
  end
  // strobe edge reference
  // Kind 1 writes, 2 reads, 0 only clocks; released data is inverted.
  task automatic frame(int n, int kind, logic [NFLAG-1:0] v, logic p);
    #7;
    for (int i = 0; i < n; i++)
    begin
      scl = 0;
      #40;
      scl = 1;
      if (i == 1)
      begin
        {wr_stb, rd_stb} = {kind == 1, kind == 2};
        {wr_mask, wr_pd, rd_val} = {v, p, v};
      end
      if (i == 2)
      begin
        {wr_stb, rd_stb} = 2'h0;
        {wr_mask, wr_pd, rd_val} = ~{wr_mask, wr_pd, rd_val};
      end
      #40;
    end
  endtask
endmodule

/* File: testbench/mmc_top_test.sv */
// Self-checking bench for the management block with a host link model.
// Expects mmc_top, mmc_host_model and mmc_monitor compiled before it.
`timescale 1ns/1ns
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module mmc_top_test;
  localparam int NF = 8;
  logic          clk = 0, rst = 1, rpin_n = 1, sel_n = 1, lp = 0;
  logic [NF-1:0] cond = '0;
  logic          scl, wstb, wpd, rstb, irq_n, prs_n, bus_en, lp_out, dnr, iev, pd_q;
  logic [NF-1:0] wmask, rval, flags, mask_q, bm;
  logic          e_sel = 0, e_lp = 0, e_pd = 0, e_iev = 0, e_dnr = 1;
  logic [NF-1:0] e_mask = '0, e_flags = '0;
  logic [22:0]   exp_q[$];
  logic [22:0]   want;
  int            err_total = 0, checked = 0, b, i;
  event          look;
  mmc_top #(.NFLAG(NF), .INIT_CYCLES(200), .RST_MIN_CYC(4)) mmc_top_i (
    .CORE_CLK(clk), .RST(rst), .SCL_CLK(scl), .MODULE_RESET_IN_N(rpin_n),
    .BUS_SELECT_IN_N(sel_n), .LOW_POWER_IN(lp), .COND_IN(cond), .LINK_WR_STB(wstb),
    .LINK_WR_MASK(wmask), .LINK_WR_PDOWN(wpd), .LINK_RD_STB(rstb), .LINK_RD_VAL(rval),
    .IRQ_OUT_N(irq_n), .PRESENT_OUT_N(prs_n), .BUS_ENABLE(bus_en), .LOW_POWER_OUT(lp_out),
    .DATA_NOT_READY(dnr), .INIT_EVENT(iev), .FLAGS(flags), .MASK_Q(mask_q), .PDOWN_Q(pd_q));
  mmc_host_model #(.NFLAG(NF)) mmc_host_model_i (.scl(scl), .wr_stb(wstb), .wr_mask(wmask),
    .wr_pd(wpd), .rd_stb(rstb), .rd_val(rval));
  // Free-running core clock.
  initial forever #25 clk = ~clk;
  // Expected outputs follow from the bench's own view of pins and writes.
  function automatic logic [22:0] expv();
    return {~(e_iev | |(e_flags & ~e_mask)), e_sel & ~e_dnr, e_lp | e_pd, e_dnr, e_iev,
      e_pd, e_mask, e_flags, 1'h0};
  endfunction
  task automatic note(int n);
    repeat (n) @(negedge clk);
    exp_q.push_back(expv());
    -> look;
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 230 && dnr !== 1'h0; k++) @(negedge clk);
  endtask
  task automatic fin(string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("checked %0d, err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Takes the oldest note and compares it with the settled outputs.
  initial forever
  begin
    @(look);
    want = exp_q.pop_front();
    `CMP({irq_n, bus_en, lp_out, dnr, iev, pd_q, mask_q, flags, prs_n}, want)
  end
  // The whole run needs about a twelfth of this span.
  initial
  begin
    #400000;
    err_total++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h9866));
    fork
      mmc_host_model_i.frame(4, 0, '0, 1'h0);
    join_none
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 0;
    sel_n = 0;
    e_sel = 1;
    note(20);
    wait_ready();
    e_dnr = 0;
    e_iev = 1;
    note(3);
    mmc_host_model_i.frame(6, 2, '0, 1'h0);
    e_iev = 0;
    note(6);
    sel_n = 1;
    e_sel = 0;
    note(8);
    fin("init and select");
    lp = 1;
    e_lp = 1;
    note(8);
    lp = 0;
    e_lp = 0;
    note(8);
    for (i = 0; i < 4; i++)
    begin
      b = (i == 0) ? 0 : $urandom_range(NF - 1);
      cond[b] = 1;
      e_flags[b] = 1;
      note(10);
      cond[b] = 0;
      mmc_host_model_i.frame(6, 2, e_flags, 1'h0);
      e_flags = '0;
      note(6);
    end
    fin("flags");
    bm = NF'($urandom);
    bm[b] = 1;
    mmc_host_model_i.frame(6, 1, bm, 1'h0);
    e_mask = bm;
    note(6);
    cond[b] = 1;
    e_flags[b] = 1;
    note(10);
    bm[b] = 0;
    mmc_host_model_i.frame(6, 1, bm, 1'h0);
    e_mask = bm;
    note(6);
    cond[b] = 0;
    mmc_host_model_i.frame(6, 2, e_flags, 1'h0);
    e_flags = '0;
    note(6);
    mmc_host_model_i.frame(6, 1, '0, 1'h1);
    e_mask = '0;
    e_pd = 1;
    note(6);
    mmc_host_model_i.frame(6, 1, '0, 1'h0);
    e_pd = 0;
    note(6);
    fin("mask and power");
    rpin_n = 0;
    repeat (2) @(negedge clk);
    rpin_n = 1;
    note(8);
    rpin_n = 0;
    e_dnr = 1;
    note(10);
    rpin_n = 1;
    wait_ready();
    e_dnr = 0;
    e_iev = 1;
    note(3);
    sel_n = 0;
    e_sel = 1;
    note(8);
    fin("module reset");
    print_verdict();
  end
endmodule
